// *** shared/pcg_defines.vh ***
`ifndef PCG_DEFINES_VH
`define PCG_DEFINES_VH

// byte offsets of the gating registers inside the peripheral window
`define PCG_OFS_ENABLE 12'h050
`define PCG_OFS_DISABLE 12'h054
`define PCG_OFS_STATUS 12'h058

// low address bits compared against the offsets above
`define PCG_OFS_W 12

// field positions shared by the enable, disable and status words
`define PCG_BIT_IO_BLOCK 0
`define PCG_BIT_FUNC 1
`define PCG_NUM_GATES 2

// state of each gated clock after reset (1 = running)
`define PCG_RST_IO_BLOCK 1'b0
`define PCG_RST_FUNC 1'b0

// default width of the peripheral window address (16 kbyte window)
`define PCG_ADDR_W 14

// apb transfer timing: one setup cycle then one access cycle
`define PCG_ACCESS_CYCLES 1

`endif

// *** src/pcg_clock_gating.v ***
// Summary of operation
// - enable word write switches selected clocks on
// - disable word write switches selected clocks off
// - status word reads current clock states
// - bit 0 is pin block clock
// - bit 1 is function logic clock
// - disabled clock stops immediately, no draining
// - re-enabled logic resumes without any reset
// - interrupt clock stops only when both off
// - gating present only in listed peripheral kinds
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "pcg_defines.vh"

module pcg_clock_gating #(
   parameter GATE_PRESENT = 1,
   parameter ADDR_W = `PCG_ADDR_W
) (
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg parallel_io_block_clk_en,
   output reg func_clk_en,
   output reg irq_clk_en
);

   ////////////////////////////////////////////////////////////////////////////////
   // address decode

   wire [`PCG_OFS_W-1:0] ofs;
   wire hit_enable;
   wire hit_disable;
   wire hit_status;
   wire word_aligned;
   wire upper_zero;
   wire mapped;

   // the window above the low offset bits must be zero for a hit
   assign ofs = paddr[`PCG_OFS_W-1:0];
   assign word_aligned = (paddr[1:0] == 2'h0);
   generate
      if (ADDR_W > `PCG_OFS_W) begin : g_upper
         assign upper_zero = (paddr[ADDR_W-1:`PCG_OFS_W] == {(ADDR_W-`PCG_OFS_W){1'b0}});
      end else begin : g_no_upper
         assign upper_zero = 1'b1;
      end
   endgenerate

   // a peripheral without a gating block decodes none of the three words
   assign hit_enable = (GATE_PRESENT != 0) && upper_zero && (ofs == `PCG_OFS_ENABLE);
   assign hit_disable = (GATE_PRESENT != 0) && upper_zero && (ofs == `PCG_OFS_DISABLE);
   assign hit_status = (GATE_PRESENT != 0) && upper_zero && (ofs == `PCG_OFS_STATUS);
   assign mapped = word_aligned && (hit_enable || hit_disable || hit_status);

   ////////////////////////////////////////////////////////////////////////////////
   // apb phase tracking

   wire setup_phase;
   wire access_done;
   wire wr_done;
   wire wr_ok;

   // setup is the first cycle of a transfer; the access completes on our pready
   assign setup_phase = psel && !penable;
   assign access_done = psel && penable && pready;
   assign wr_done = access_done && pwrite;
   // errored writes have no effect; lane 0 carries both gate bits
   assign wr_ok = wr_done && !pslverr && pstrb[0];

   ////////////////////////////////////////////////////////////////////////////////
   // command decode

   wire [`PCG_NUM_GATES-1:0] wr_bits;
   wire [`PCG_NUM_GATES-1:0] set_req;
   wire [`PCG_NUM_GATES-1:0] clr_req;

   // only ones act; zeros in a command word leave the clock alone
   assign wr_bits = pwdata[`PCG_NUM_GATES-1:0];
   assign set_req = (wr_ok && hit_enable) ? wr_bits : {`PCG_NUM_GATES{1'b0}};
   assign clr_req = (wr_ok && hit_disable) ? wr_bits : {`PCG_NUM_GATES{1'b0}};

   ////////////////////////////////////////////////////////////////////////////////
   // gate state bits

   wire iob_nxt;
   wire func_nxt;
   wire iob_state;
   wire func_state;

   generate
      if (GATE_PRESENT != 0) begin : g_gates
         // pin block clock
         pcg_gate_bit #(
            .RST_VAL(`PCG_RST_IO_BLOCK)
         ) u_iob (
            .pclk(pclk),
            .presetn(presetn),
            .ce(ce),
            .set_req(set_req[`PCG_BIT_IO_BLOCK]),
            .clr_req(clr_req[`PCG_BIT_IO_BLOCK]),
            .state_nxt(iob_nxt),
            .state_r(iob_state)
         );

         // function logic clock
         pcg_gate_bit #(
            .RST_VAL(`PCG_RST_FUNC)
         ) u_func (
            .pclk(pclk),
            .presetn(presetn),
            .ce(ce),
            .set_req(set_req[`PCG_BIT_FUNC]),
            .clr_req(clr_req[`PCG_BIT_FUNC]),
            .state_nxt(func_nxt),
            .state_r(func_state)
         );
      end else begin : g_no_gates
         // without a gating block both clocks simply run
         assign iob_nxt = 1'b1;
         assign func_nxt = 1'b1;
         assign iob_state = 1'b1;
         assign func_state = 1'b1;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // clock enable outputs

   // enables load from the next-state values so a stop lands on the very edge
   // that completes the disable write; no drain counter is kept on purpose
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         parallel_io_block_clk_en <= (GATE_PRESENT != 0) ? `PCG_RST_IO_BLOCK : 1'b1;
         func_clk_en <= (GATE_PRESENT != 0) ? `PCG_RST_FUNC : 1'b1;
         irq_clk_en <= (GATE_PRESENT != 0) ? (`PCG_RST_IO_BLOCK | `PCG_RST_FUNC) : 1'b1;
      end else if (ce) begin
         parallel_io_block_clk_en <= iob_nxt;
         func_clk_en <= func_nxt;
         // shared interrupt logic keeps running while either side is on
         irq_clk_en <= iob_nxt | func_nxt;
      end
   end

   // gated logic downstream is never reset from here; it simply resumes
   // when its enable returns, which is why no reset output exists at all

   ////////////////////////////////////////////////////////////////////////////////
   // read data

   reg [31:0] rd_word;

   // command words are write-only and read zero; unused status bits are zero
   always @* begin
      rd_word = 32'h0000_0000;
      if (hit_status && word_aligned) begin
         rd_word[`PCG_BIT_IO_BLOCK] = iob_state;
         rd_word[`PCG_BIT_FUNC] = func_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // apb response

   // answers are registered in setup so every bus output comes from a flop;
   // the cost is one fixed wait-free access cycle after each setup
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (ce) begin
         if (setup_phase) begin
            pready <= 1'b1;
            // unmapped offsets and writes to the status word are errors
            pslverr <= !mapped || (pwrite && hit_status);
            prdata <= pwrite ? 32'h0000_0000 : rd_word;
         end else if (access_done) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
         end
      end
   end

endmodule // pcg_clock_gating

// *** src/pcg_gate_bit.v ***
`timescale 1ns/1ps
`include "pcg_defines.vh"

// one set/clear state bit for a single gated clock
module pcg_gate_bit #(
   parameter RST_VAL = 1'b0
) (
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire set_req,
   input wire clr_req,
   output wire state_nxt,
   output reg state_r
);

   // set and clear come from different registers and never meet in one cycle;
   // if they ever did, set wins so that a clock is not stopped by accident
   assign state_nxt = set_req ? 1'b1 : (clr_req ? 1'b0 : state_r);

   // no reinitialisation on re-enable: the bit only flips, nothing downstream is reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= RST_VAL;
      end else if (ce) begin
         state_r <= state_nxt;
      end
   end

endmodule // pcg_gate_bit

// *** tb/pcg_clock_gating_asserts.sv ***
`timescale 1ns/1ps
`include "pcg_defines.vh"
module pcg_clock_gating_asserts #(
   parameter ADDR_W = `PCG_ADDR_W
) (
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire parallel_io_block_clk_en,
   input wire func_clk_en,
   input wire irq_clk_en
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // accepted write completing with the low byte strobed
   sequence wr_end;
      psel && penable && pready && pwrite && ce && pstrb[0] && !pslverr;
   endsequence
   sequence setup_go;
      psel && !penable && ce;
   endsequence
   ready_one_a: assert property (setup_go |=> pready ##1 !pready) else $error("bad ready");
   blk_on_a: assert property (wr_end ##0 (paddr == `PCG_OFS_ENABLE && pwdata[0]) |=>
      parallel_io_block_clk_en) else $error("pin clock not on");
   func_on_a: assert property (wr_end ##0 (paddr == `PCG_OFS_ENABLE && pwdata[1]) |=> func_clk_en)
      else $error("function clock not on");
   blk_off_a: assert property (wr_end ##0 (paddr == `PCG_OFS_DISABLE && pwdata[0]) |=>
      !parallel_io_block_clk_en) else $error("pin clock not off");
   func_off_a: assert property (wr_end ##0 (paddr == `PCG_OFS_DISABLE && pwdata[1]) |=> !func_clk_en)
      else $error("function clock not off");
   irq_or_a: assert property (irq_clk_en == (parallel_io_block_clk_en || func_clk_en))
      else $error("irq clock");
   status_rd_a: assert property (setup_go ##0 (!pwrite && paddr == `PCG_OFS_STATUS) |=>
      prdata == {30'h0, func_clk_en, parallel_io_block_clk_en}) else $error("bad status");
   hold_state_a: assert property (!(psel && penable && pready && pwrite) |=>
      $stable({parallel_io_block_clk_en, func_clk_en})) else $error("state moved");
   zero_bits_a: assert property (wr_end ##0 (pwdata[1:0] == 2'h0) |=>
      $stable({parallel_io_block_clk_en, func_clk_en})) else $error("zero bits acted");
   rd_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
endmodule // pcg_clock_gating_asserts
bind pcg_clock_gating pcg_clock_gating_asserts #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk),
   .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .parallel_io_block_clk_en(parallel_io_block_clk_en), .func_clk_en(func_clk_en),
   .irq_clk_en(irq_clk_en));

// *** tb/tb.sv ***
`timescale 1ns/1ps
`include "pcg_defines.vh"
module tb;
   reg pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg [13:0] paddr = 14'h0;
   reg [31:0] pwdata = 32'h0, rd;
   reg [3:0] pstrb = 4'hf;
   reg err;
   wire [31:0] prdata;
   wire pready, pslverr, parallel_io_block_clk_en, func_clk_en, irq_clk_en;
   integer bad_count = 0, total_checks = 0;
   pcg_clock_gating #(.GATE_PRESENT(1), .ADDR_W(14)) DUT (.pclk(pclk), .presetn(presetn),
      .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .parallel_io_block_clk_en(parallel_io_block_clk_en), .func_clk_en(func_clk_en),
      .irq_clk_en(irq_clk_en));
   initial forever #10 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input [31:0] got, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // one apb transfer; holds the request until pready is seen, only the watchdog ends a hang
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= {2'h0, a};
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) @(posedge pclk);
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   // let the completing edge land before looking at the enables
   task chk_en(input [2:0] e);
      #1 chk({irq_clk_en, func_clk_en, parallel_io_block_clk_en}, e);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_on_off;
      begin
         chk_en(3'h0);
         apb(1'b1, `PCG_OFS_ENABLE, 32'h1);
         chk_en(3'h5);
         apb(1'b1, `PCG_OFS_ENABLE, 32'h2);
         chk_en(3'h7);
         apb(1'b0, `PCG_OFS_STATUS, 32'h0);
         chk(rd, 32'h3);
         apb(1'b1, `PCG_OFS_DISABLE, 32'h1);
         chk_en(3'h6);
         apb(1'b1, `PCG_OFS_STATUS, 32'h1);
         chk(err, 1'b1);
         apb(1'b1, `PCG_OFS_ENABLE, 32'h1);
         chk_en(3'h7);
         apb(1'b1, `PCG_OFS_DISABLE, 32'h3);
         chk_en(3'h0);
      end
   endtask
   // zero bits, reserved bits and an unstrobed write must leave state alone
   task t_zero;
      begin
         apb(1'b1, `PCG_OFS_ENABLE, 32'hfffffffc);
         chk_en(3'h0);
         @(posedge pclk);
         pstrb <= 4'h0;
         apb(1'b1, `PCG_OFS_ENABLE, 32'h3);
         chk_en(3'h0);
         @(posedge pclk);
         pstrb <= 4'hf;
         apb(1'b1, `PCG_OFS_ENABLE, 32'hffffffff);
         apb(1'b0, `PCG_OFS_STATUS, 32'h0);
         chk(rd, 32'h3);
         apb(1'b0, 12'h05c, 32'h0);
         chk(err, 1'b1);
      end
   endtask
   // ce low freezes the bus too, so the setup is simply held until ce returns
   task t_ce;
      begin
         @(posedge pclk);
         ce <= 1'b0;
         psel <= 1'b1;
         pwrite <= 1'b1;
         paddr <= {2'h0, `PCG_OFS_DISABLE};
         pwdata <= 32'h1;
         repeat (3) @(posedge pclk);
         #1 chk(pready, 1'b0);
         chk_en(3'h7);
         @(posedge pclk);
         ce <= 1'b1;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) @(posedge pclk);
         psel <= 1'b0;
         penable <= 1'b0;
         chk_en(3'h6);
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", total_checks, bad_count);
         if (bad_count == 0 && total_checks > 0) $display("Test passed");
         else $display("Test failed");
         $finish;
      end
   endtask
   // main sequence after five cycles of reset
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_on_off;
      t_zero;
      t_ce;
      print_verdict;
   end
   // watchdog: the run needs well under a thousand cycles
   initial begin
      #100000;
      bad_count = bad_count + 1;
      print_verdict;
   end
endmodule // tb
